// ===== include/spi_engine_pkg.sv
`default_nettype none
package spi_engine_pkg;

  // ****************************************************************
  // Clock rates and serial clock limits
  // ****************************************************************
  localparam int CORE_CLK_KHZ        = 20000;
  localparam int SYNC_DIV_MAX_KBPS   = 2149;
  localparam int SYNC_NODIV_MAX_KBPS = 3366;
  localparam int ASYNC_MAX_KHZ       = 100000;

  // Least half period in core cycles for a rate cap, rounded up
  function automatic int min_half(input int rate_k);
    int h;
    h = (CORE_CLK_KHZ + 2 * rate_k - 1) / (2 * rate_k);
    return (h < 1) ? 1 : h;
  endfunction

  localparam logic [7:0] HALF_SYNC_DIV   = 8'(min_half(SYNC_DIV_MAX_KBPS));
  localparam logic [7:0] HALF_SYNC_NODIV =
    8'(min_half(SYNC_NODIV_MAX_KBPS));
  localparam logic [7:0] HALF_ASYNC      = 8'(min_half(ASYNC_MAX_KHZ));

  // ****************************************************************
  // Word sizes, counts and reset values
  // ****************************************************************
  localparam int          WORD_W    = 32;
  localparam int          SEL_IDX_W = 4;
  localparam logic [6:0]  EDGES_8   = 7'h10;
  localparam logic [6:0]  EDGES_32  = 7'h40;
  localparam logic [6:0]  BITS_8    = 7'h08;
  localparam logic [6:0]  BITS_32   = 7'h20;
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [7:0]  DIV_RST   = 8'h00;

  // ****************************************************************
  // Modes and carriers
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_0 = 2'h0,
    MODE_1 = 2'h1,
    MODE_2 = 2'h2,
    MODE_3 = 2'h3
  } spi_mode_t;

  typedef struct packed {
    logic       slave;
    spi_mode_t  mode;
    logic       word32;
    logic       miso_en;
    logic       mosi_en;
    logic       async_en;
    logic       sync_clkdiv;
    logic [7:0] half_div;
  } spi_cfg_t;

  typedef struct packed {
    logic                 open;
    logic                 close;
    logic [SEL_IDX_W-1:0] sel_idx;
    logic [15:0]          setup_cyc;
    logic [15:0]          gap_cyc;
  } spi_cmd_t;

  function automatic logic mode_cpol(input spi_mode_t m);
    return m[1];
  endfunction

  function automatic logic mode_cpha(input spi_mode_t m);
    return ~(m[1] ^ m[0]);
  endfunction

endpackage
`default_nettype wire

// ===== logic/spi_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module spi_pin_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_rstn,
  // Pins and synchronised levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  if (W < 1) begin : g_bad_width
    $error("spi_pin_sync: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  always_comb begin
    d      = q;
    d.meta = i_async;
    d.sync = q.meta;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.sync;

endmodule // spi_pin_sync
`default_nettype wire

// ===== logic/spi_rx_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module spi_rx_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_rstn,
  // Fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Drain side
  output logic              o_out_valid,
  output logic      [W-1:0] o_out_data,
  input  wire logic         i_out_ready
);

  localparam int         AW   = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  if (DEPTH < 2 || (2 ** AW) != DEPTH || W < 1) begin : g_bad_shape
    $error("spi_rx_fifo: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic [AW:0] used;

  // Output register is a slot too, so DEPTH words in all
  assign used = q.cnt + {{AW{1'b0}}, q.ov};

  always_comb begin
    logic push;
    logic pull;
    push = i_in_valid && (used != FULL);
    pull = (q.cnt != '0) && (!q.ov || i_out_ready);
    d    = q;
    if (q.ov && i_out_ready) begin
      d.ov = 1'b0;
    end
    // Output word sits in a register, refilled as it is taken
    if (pull) begin
      d.od = q.mem[q.rp];
      d.ov = 1'b1;
      d.rp = q.rp + 1'b1;
    end
    if (push) begin
      d.mem[q.wp] = i_in_data;
      d.wp        = q.wp + 1'b1;
    end
    d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pull};
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_in_ready  = (used != FULL);
  assign o_out_valid = q.ov;
  assign o_out_data  = q.od;

endmodule // spi_rx_fifo
`default_nettype wire

// ===== logic/spi_master_slave_engine.sv
`timescale 1ns/10ps
`default_nettype none
module spi_master_slave_engine
  import spi_engine_pkg::*;
#(
  parameter int N_SEL      = 4,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rstn,
  // Configuration and commands
  input  wire spi_cfg_t          i_cfg,
  input  wire spi_cmd_t          i_cmd,
  // Transmit words
  input  wire logic              i_tx_valid,
  input  wire logic [WORD_W-1:0] i_tx_data,
  output logic                   o_tx_ready,
  // Received words
  output logic                   o_rx_valid,
  output logic      [WORD_W-1:0] o_rx_data,
  input  wire logic              i_rx_ready,
  // Serial clock pin
  input  wire logic              i_sclk,
  output logic                   o_sclk,
  output logic                   o_sclk_oe,
  // Master-out pin
  input  wire logic              i_mosi,
  output logic                   o_mosi,
  output logic                   o_mosi_oe,
  // Master-in pin
  input  wire logic              i_miso,
  output logic                   o_miso,
  output logic                   o_miso_oe,
  // Select pins
  output logic      [N_SEL-1:0]  o_sel,
  input  wire logic              i_sel,
  // Status
  output logic                   o_session,
  output logic                   o_slv_start,
  output logic                   o_slv_end,
  output logic                   o_overrun,
  output logic                   o_cfg_err
);

  if (N_SEL < 1 || N_SEL > (2 ** SEL_IDX_W)) begin : g_bad_nsel
    $error("spi_master_slave_engine: N_SEL out of range");
  end

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [5:0] {
    M_IDLE  = 6'h01,
    M_GAP   = 6'h02,
    M_SETUP = 6'h04,
    M_READY = 6'h08,
    M_SHIFT = 6'h10,
    M_STORE = 6'h20
  } mst_state_t;

  typedef struct packed {
    mst_state_t           st;
    logic [N_SEL-1:0]     sel;
    logic [SEL_IDX_W-1:0] last_idx;
    logic [SEL_IDX_W-1:0] want_idx;
    logic [15:0]          gap_cnt;
    logic [15:0]          gap_req;
    logic [15:0]          setup_cnt;
    logic [7:0]           div_cnt;
    logic [6:0]           edge_cnt;
    logic [WORD_W-1:0]    tx_sh;
    logic [WORD_W-1:0]    rx_sh;
    logic [WORD_W-1:0]    hold;
    logic                 hold_full;
    logic                 reload;
    logic                 sclk;
    logic                 sclk_oe;
    logic                 mosi;
    logic                 mosi_oe;
    logic                 miso;
    logic                 miso_oe;
    logic                 tx_ready;
    logic                 close_pend;
    logic                 push;
    logic                 session;
    logic                 slv_start;
    logic                 slv_end;
    logic                 overrun;
    logic                 cfg_err;
    logic                 sclk_prev;
    logic                 sel_prev;
  } eng_state_t;

  localparam eng_state_t ENG_RST = '{st: M_IDLE, default: '0};

  eng_state_t q;
  eng_state_t d;

  logic [3:0]        pins_s;
  logic              sclk_s;
  logic              mosi_s;
  logic              miso_s;
  logic              sel_s;
  logic              fifo_in_ready;
  logic [WORD_W-1:0] push_data;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // 8-bit words ride in the top byte so both sizes leave MSB first
  function automatic logic [WORD_W-1:0] align_tx(
    input logic [WORD_W-1:0] w,
    input logic              w32
  );
    return w32 ? w : {w[7:0], 24'h000000};
  endfunction

  // Launch next bit; at a word boundary the held word is taken
  function automatic eng_state_t launch(
    input eng_state_t s,
    input logic       to_miso
  );
    eng_state_t        r;
    logic [WORD_W-1:0] src;
    r   = s;
    src = s.tx_sh;
    if (s.reload) begin
      src         = s.hold_full ? s.hold : '0;
      r.hold_full = 1'b0;
      r.reload    = 1'b0;
    end
    if (to_miso) begin
      r.miso = src[WORD_W-1];
    end else begin
      r.mosi = src[WORD_W-1];
    end
    r.tx_sh = {src[WORD_W-2:0], 1'b0};
    return r;
  endfunction

  // ****************************************************************
  // Pin synchronisers and receive buffer
  // ****************************************************************
  spi_pin_sync #(
    .W (4)
  ) u_pin_sync (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_async    ({i_sclk, i_mosi, i_miso, i_sel}),
    .o_sync     (pins_s)
  );

  assign sclk_s = pins_s[3];
  assign mosi_s = pins_s[2];
  assign miso_s = pins_s[1];
  assign sel_s  = pins_s[0];

  // Short words are returned zero-extended
  assign push_data = i_cfg.word32 ? q.rx_sh : {24'h000000, q.rx_sh[7:0]};

  spi_rx_fifo #(
    .W     (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .i_core_clk  (i_core_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (q.push),
    .i_in_data   (push_data),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (o_rx_valid),
    .o_out_data  (o_rx_data),
    .i_out_ready (i_rx_ready)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic              cpol;
    logic              cpha;
    logic              lead;
    logic              tick;
    logic [7:0]        half;
    logic [7:0]        lim;
    logic [6:0]        edges;
    logic [6:0]        bits;
    logic [WORD_W-1:0] word;
    cpol  = mode_cpol(i_cfg.mode);
    cpha  = mode_cpha(i_cfg.mode);
    edges = i_cfg.word32 ? EDGES_32 : EDGES_8;
    bits  = i_cfg.word32 ? BITS_32 : BITS_8;
    word  = align_tx(i_tx_data, i_cfg.word32);
    lead  = 1'b0;
    // Divider floor follows the selected master flavour
    lim   = i_cfg.async_en ? HALF_ASYNC :
            (i_cfg.sync_clkdiv ? HALF_SYNC_DIV : HALF_SYNC_NODIV);
    half  = (i_cfg.half_div > lim) ? i_cfg.half_div : lim;
    tick  = (q.div_cnt >= half - 8'h01);

    d           = q;
    d.push      = 1'b0;
    d.slv_start = 1'b0;
    d.slv_end   = 1'b0;
    d.sclk_prev = sclk_s;
    d.sel_prev  = sel_s;

    // Deselect time runs down after every close
    if (q.gap_cnt != CNT_RST) begin
      d.gap_cnt = q.gap_cnt - 16'h0001;
    end

    if (i_cfg.slave) begin
      // ************************************************************
      // Slave role
      // ************************************************************
      d.st      = M_IDLE;
      d.sel     = '0;
      d.sclk_oe = 1'b0;
      d.mosi_oe = 1'b0;
      if (sel_s && !q.sel_prev) begin
        d.session   = 1'b1;
        d.slv_start = 1'b1;
        d.overrun   = 1'b0;
        d.edge_cnt  = '0;
        d.reload    = 1'b1;
        d.miso_oe   = i_cfg.miso_en;
        if (!cpha) begin
          d = launch(d, 1'b1);
        end
      end else if (!sel_s && q.sel_prev) begin
        d.session = 1'b0;
        d.slv_end = 1'b1;
        d.miso_oe = 1'b0;
      end else if (sel_s && q.session && sclk_s != q.sclk_prev) begin
        lead = (sclk_s != cpol);
        if (lead == cpha) begin
          d = launch(d, 1'b1);
        end else begin
          // Master-out is always sampled
          d.rx_sh    = {q.rx_sh[WORD_W-2:0], mosi_s};
          d.edge_cnt = q.edge_cnt + 7'h01;
          if (q.edge_cnt + 7'h01 == bits) begin
            d.edge_cnt = '0;
            d.reload   = 1'b1;
            if (fifo_in_ready) begin
              d.push = 1'b1;
            end else begin
              d.overrun = 1'b1;
            end
          end
        end
      end
      // Words wait in the hold register until the next boundary
      if (i_tx_valid && q.tx_ready) begin
        d.hold      = word;
        d.hold_full = 1'b1;
      end
      d.tx_ready = !d.hold_full;
    end else begin
      // ************************************************************
      // Master role
      // ************************************************************
      d.sclk_oe = 1'b1;
      d.mosi_oe = i_cfg.mosi_en;
      d.miso_oe = 1'b0;
      d.reload  = 1'b0;
      if (i_cmd.close && (q.st == M_SHIFT || q.st == M_STORE)) begin
        d.close_pend = 1'b1;
        d.gap_req    = i_cmd.gap_cyc;
      end
      unique case (q.st)
        M_IDLE: begin
          d.sclk = cpol;
          if (i_cmd.open) begin
            if (32'(i_cmd.sel_idx) >= N_SEL ||
                (i_cfg.async_en && !i_cfg.miso_en)) begin
              d.cfg_err = 1'b1;
            end else begin
              d.cfg_err   = 1'b0;
              d.want_idx  = i_cmd.sel_idx;
              d.setup_cnt = i_cmd.setup_cyc;
              d.st        = M_GAP;
            end
          end
        end
        M_GAP: begin
          if (q.want_idx != q.last_idx || q.gap_cnt == CNT_RST) begin
            d.sel     = {{(N_SEL-1){1'b0}}, 1'b1} << q.want_idx;
            d.session = 1'b1;
            d.st      = M_SETUP;
          end
        end
        M_SETUP: begin
          if (q.setup_cnt == CNT_RST) begin
            d.st = M_READY;
          end else begin
            d.setup_cnt = q.setup_cnt - 16'h0001;
          end
        end
        M_READY: begin
          if (i_cmd.close || q.close_pend) begin
            d.sel        = '0;
            d.session    = 1'b0;
            d.gap_cnt    = q.close_pend ? q.gap_req : i_cmd.gap_cyc;
            d.last_idx   = q.want_idx;
            d.close_pend = 1'b0;
            d.st         = M_IDLE;
          end else if (i_tx_valid && q.tx_ready) begin
            d.div_cnt  = DIV_RST;
            d.edge_cnt = '0;
            d.st       = M_SHIFT;
            if (cpha) begin
              d.tx_sh = word;
            end else begin
              d.mosi  = word[WORD_W-1];
              d.tx_sh = {word[WORD_W-2:0], 1'b0};
            end
          end
        end
        M_SHIFT: begin
          if (tick) begin
            d.div_cnt  = DIV_RST;
            d.sclk     = !q.sclk;
            d.edge_cnt = q.edge_cnt + 7'h01;
            lead       = !q.edge_cnt[0];
            if (lead == cpha) begin
              d = launch(d, 1'b0);
            end else if (i_cfg.miso_en) begin
              d.rx_sh = {q.rx_sh[WORD_W-2:0], miso_s};
            end
            if (q.edge_cnt + 7'h01 == edges) begin
              d.st = M_STORE;
            end
          end else begin
            d.div_cnt = q.div_cnt + 8'h01;
          end
        end
        M_STORE: begin
          // With master-in enabled, stall with the clock idle until the buffer has room
          if (!i_cfg.miso_en) begin
            d.st = M_READY;
          end else if (fifo_in_ready) begin
            d.push = 1'b1;
            d.st   = M_READY;
          end
        end
        default: begin
          d.st = M_IDLE;
        end
      endcase
      d.tx_ready = (d.st == M_READY) && !d.close_pend;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      q <= ENG_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_tx_ready  = q.tx_ready;
  assign o_sclk      = q.sclk;
  assign o_sclk_oe   = q.sclk_oe;
  assign o_mosi      = q.mosi;
  assign o_mosi_oe   = q.mosi_oe;
  assign o_miso      = q.miso;
  assign o_miso_oe   = q.miso_oe;
  assign o_sel       = q.sel;
  assign o_session   = q.session;
  assign o_slv_start = q.slv_start;
  assign o_slv_end   = q.slv_end;
  assign o_overrun   = q.overrun;
  assign o_cfg_err   = q.cfg_err;

endmodule // spi_master_slave_engine
`default_nettype wire

// ===== bench/spi_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
  // Bus side
  input  wire logic        i_sel,
  input  wire logic        i_sclk,
  input  wire logic        i_mosi,
  output logic             o_miso,
  // Setup and capture
  input  wire logic [1:0]  i_mode,
  input  wire logic        i_w32,
  input  wire logic [31:0] i_word,
  output logic      [31:0] o_rx
);
  logic [31:0] sh;
  logic        ph;
  initial begin
    o_miso = 1'b0;
    o_rx   = 32'h0;
    sh     = 32'h0;
  end
  always_comb ph = (i_mode == 2'h0) || (i_mode == 2'h3);
  always @(posedge i_sel) begin
    sh = i_w32 ? i_word : {i_word[7:0], 24'h0};
    o_rx = 32'h0;
    // Phase 1 leaves the line unsettled until the first edge
    o_miso = ph ? ~o_miso : sh[31];
    if (!ph) sh = sh << 1;
  end
  // Released line shows the inverse of its last level
  always @(negedge i_sel) o_miso = ~o_miso;
  always @(i_sclk) begin
    if (i_sel) begin
      if ((i_sclk != i_mode[1]) != ph) o_rx = {o_rx[30:0], i_mosi};
      else begin
        o_miso = sh[31];
        sh = sh << 1;
      end
    end
  end
endmodule // spi_slave_model
`default_nettype wire

// ===== bench/spi_engine_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module spi_engine_assertions
  import spi_engine_pkg::*;
#(
  parameter int N_SEL = 4
) (
  // Clock and reset
  input wire logic              i_core_clk,
  input wire logic              i_rstn,
  // Inputs watched
  input wire spi_cfg_t          i_cfg,
  input wire spi_cmd_t          i_cmd,
  input wire logic              i_rx_ready,
  // Outputs watched
  input wire logic              o_sclk,
  input wire logic              o_sclk_oe,
  input wire logic              o_miso_oe,
  input wire logic [N_SEL-1:0]  o_sel,
  input wire logic              o_session,
  input wire logic              o_tx_ready,
  input wire logic              o_rx_valid,
  input wire logic [WORD_W-1:0] o_rx_data,
  input wire logic              o_slv_start,
  input wire logic              o_slv_end,
  input wire logic              o_cfg_err
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_opened;
    $rose(o_session) && !i_cfg.slave;
  endsequence
  sequence s_open_bad;
    i_cmd.open && !o_session && !i_cfg.slave &&
      (i_cmd.sel_idx >= N_SEL || (i_cfg.async_en && !i_cfg.miso_en));
  endsequence
  a_open_refused: assert property (s_open_bad |=> o_cfg_err)
    else $error("bad open not flagged");
  a_sel_onehot: assert property ($onehot0(o_sel))
    else $error("several selects active");
  a_sel_session: assert property (!i_cfg.slave |-> o_session == |o_sel)
    else $error("select and session disagree");
  a_setup_exact: assert property (s_opened ##0
    i_cmd.setup_cyc == 16'h0003 |-> !o_tx_ready [*4] ##1 o_tx_ready)
    else $error("setup delay wrong");
  a_gap_min: assert property ($fell(o_session) && !i_cfg.slave
    |-> !o_session [*2])
    else $error("select reasserted too soon");
  a_idle_level: assert property (!o_session && o_sclk_oe &&
    $stable(i_cfg.mode) && $stable(o_session) |-> o_sclk == i_cfg.mode[1])
    else $error("idle clock level wrong");
  a_miso_quiet: assert property (i_cfg.slave && !o_session &&
    !$past(o_session) |-> !o_miso_oe)
    else $error("slave drives while unselected");
  a_start_pulse: assert property (o_slv_start
    |-> i_cfg.slave ##1 !o_slv_start)
    else $error("start notice not a pulse");
  a_end_pulse: assert property (o_slv_end |=> !o_slv_end)
    else $error("end notice not a pulse");
  a_rate_floor: assert property ($changed(o_sclk) && o_session &&
    !i_cfg.slave && !i_cfg.async_en && i_cfg.sync_clkdiv
    |=> $stable(o_sclk) [*4])
    else $error("serial clock above rate cap");
  a_rx_hold: assert property (o_rx_valid && !i_rx_ready
    |=> o_rx_valid && $stable(o_rx_data))
    else $error("received word dropped");
endmodule // spi_engine_assertions
bind spi_master_slave_engine spi_engine_assertions #(.N_SEL(N_SEL)) u_chk (.*);
`default_nettype wire

// ===== bench/spi_master_slave_engine_tb.sv
`timescale 1ns/10ps
`default_nettype none
module spi_master_slave_engine_tb
  import spi_engine_pkg::*;
;
  logic i_core_clk, i_rstn, i_tx_valid, i_rx_ready, i_sel, es, em, mmi;
  logic o_tx_ready, o_rx_valid, o_sclk, o_sclk_oe, o_mosi, o_mosi_oe;
  logic o_miso, o_miso_oe, o_session, o_slv_start, o_slv_end;
  logic o_overrun, o_cfg_err;
  logic [31:0] i_tx_data, o_rx_data, mw, mrx, q[$];
  logic [3:0]  o_sel, lidx;
  spi_cfg_t    i_cfg;
  spi_cmd_t    i_cmd;
  int miscompares = 0, checks = 0, cyc = 0, lfall = 0, ns = 0, ne = 0;
  wire logic i_sclk = o_sclk_oe ? o_sclk : es;
  wire logic i_mosi = o_mosi_oe ? o_mosi : em;
  wire logic i_miso = o_miso_oe ? o_miso : mmi;
  wire logic [3:0] sg = {o_overrun, o_rx_valid, o_session, o_tx_ready};

  spi_master_slave_engine #(.N_SEL(4), .FIFO_DEPTH(8)) dut (.*);
  spi_slave_model mdl (.i_sel(|o_sel), .i_sclk(i_sclk), .i_mosi(i_mosi),
    .o_miso(mmi), .i_mode(i_cfg.mode), .i_w32(i_cfg.word32), .i_word(mw),
    .o_rx(mrx));

  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    ns <= ns + int'(o_slv_start);
    ne <= ne + int'(o_slv_end);
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] msk();
    return i_cfg.word32 ? 32'hffffffff : 32'h000000ff;
  endfunction
  function automatic logic cpha_of(input logic [1:0] m);
    return (m == 2'h0) || (m == 2'h3);
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wt(input int s, input logic v);
    int n;
    for (n = 0; n < 4000; n++) begin
      @(posedge i_core_clk);
      if (sg[s] === v) return;
    end
    miscompares++;
    results();
  endtask
  task automatic cmdp(input logic op, input logic [3:0] idx);
    i_cmd.open <= op;
    i_cmd.close <= !op;
    i_cmd.sel_idx <= idx;
    @(posedge i_core_clk);
    i_cmd.open <= 1'b0;
    i_cmd.close <= 1'b0;
  endtask
  task automatic setm(input logic [1:0] m, input logic w32);
    i_cfg.mode <= spi_mode_t'(m);
    i_cfg.word32 <= w32;
    i_cfg.sync_clkdiv <= m[0];
    es <= m[1];
    repeat (4) @(posedge i_core_clk);
  endtask
  task automatic push(input logic [31:0] w);
    i_tx_valid <= 1'b1;
    i_tx_data <= w;
    wt(0, 1'b1);
    i_tx_valid <= 1'b0;
  endtask
  task automatic pop(input logic [31:0] e);
    wt(2, 1'b1);
    chk(o_rx_data, e);
    i_rx_ready <= 1'b1;
    @(posedge i_core_clk);
    i_rx_ready <= 1'b0;
  endtask
  task automatic mx(input logic [3:0] idx, input logic [31:0] w);
    logic [31:0] r;
    r = $urandom;
    mw <= r;
    cmdp(1'b1, idx);
    wt(1, 1'b1);
    chk(32'(o_sel), 32'h1 << idx);
    if (idx == lidx) chk(32'(cyc - lfall >= 21), 32'h1);
    push(w);
    wt(0, 1'b1);
    cmdp(1'b0, idx);
    wt(1, 1'b0);
    lfall = cyc;
    lidx = idx;
    pop(r & msk());
    chk(mrx & msk(), w & msk());
  endtask
  // External master; half period of four core cycles
  task automatic sx(input logic [31:0] w, input int nb,
                    output logic [31:0] got);
    logic [31:0] sh;
    int i;
    logic ph;
    ph = cpha_of(i_cfg.mode);
    sh = w << (32 - nb);
    got = 32'h0;
    i_sel <= 1'b1;
    if (!ph) begin
      em <= sh[31];
      sh = sh << 1;
    end
    repeat (8) @(posedge i_core_clk);
    for (i = 0; i < 2 * nb; i++) begin
      repeat (3) @(posedge i_core_clk);
      @(negedge i_core_clk);
      if (i[0] == ph) got = {got[30:0], i_miso};
      @(posedge i_core_clk);
      es <= ~es;
      if (i[0] != ph) begin
        em <= sh[31];
        sh = sh << 1;
      end
    end
    repeat (6) @(posedge i_core_clk);
    i_sel <= 1'b0;
    em <= ~em;
    repeat (12) @(posedge i_core_clk);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int k;
    logic [31:0] r, g, h;
    i_rstn = 1'b0;
    i_cfg = '0;
    i_cfg.half_div = 8'h04;
    i_cfg.miso_en = 1'b1;
    i_cfg.mosi_en = 1'b1;
    i_cmd = '0;
    i_cmd.setup_cyc = 16'h0003;
    i_cmd.gap_cyc = 16'h0014;
    {i_tx_valid, i_rx_ready, i_sel, es, em} = 5'h0;
    i_tx_data = 32'h0;
    mw = 32'h0;
    lidx = 4'hf;
    void'($urandom(32'h6bd4));
    repeat (6) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    for (k = 0; k < 8; k++) begin
      setm(k[1:0], k[2]);
      mx(4'($urandom % 4), $urandom);
    end
    mx(4'h2, 32'h80000001);
    mx(4'h2, 32'h7ffffffe);
    cmdp(1'b1, 4'h9);
    @(posedge i_core_clk);
    chk(32'(o_cfg_err), 32'h1);
    i_cfg.async_en <= 1'b1;
    i_cfg.miso_en <= 1'b0;
    cmdp(1'b1, 4'h0);
    @(posedge i_core_clk);
    chk(32'(o_cfg_err), 32'h1);
    i_cfg.miso_en <= 1'b1;
    mx(4'h1, $urandom);
    chk(32'(o_cfg_err), 32'h0);
    i_cfg.async_en <= 1'b0;
    i_cfg.slave <= 1'b1;
    for (k = 0; k < 8; k++) begin
      setm(k[1:0], k[2]);
      h = $urandom;
      r = $urandom;
      push(h);
      sx(r, k[2] ? 32 : 8, g);
      chk(g & msk(), h & msk());
      pop(r & msk());
      chk(ns, k + 1);
      chk(ne, k + 1);
    end
    setm(2'h1, 1'b0);
    for (k = 0; k < 9; k++) begin
      r = (k == 0) ? 32'h000000ff : $urandom;
      q.push_back(r & 32'h000000ff);
      sx(r, 8, g);
    end
    chk(32'(o_overrun), 32'h1);
    for (k = 0; k < 8; k++) pop(q[k]);
    for (k = 0; k < 16; k++) begin
      repeat (4) @(posedge i_core_clk);
      es <= ~es;
      em <= 1'($urandom);
    end
    repeat (12) @(posedge i_core_clk);
    chk(32'(o_rx_valid), 32'h0);
    results();
  end
endmodule // spi_master_slave_engine_tb
`default_nettype wire
